// [eep_pkg.sv]
// Constants and carrier types of the serial EEPROM read path
// Overview of operation
// - A read starts like a write: START, control byte, direction bit one.
// - Address counter holds last accessed location plus one for current-address reads.
// - Matching read control byte is acknowledged, then one byte from the counter shifts out.
// - Master ends a read with no acknowledge and STOP; device releases data line.
// - Write control byte plus word address loads the pointer; nothing is stored.
// - After a random read the counter points past the byte just sent.
// - Master acknowledge makes the device send the next sequential byte.
// - Pointer increments by one per byte so whole memory streams in one read.
// - Three chip-select bits of the control byte must match the three strap inputs.
// - Chip-select bits may serve as high address bits; sequential reads stay in-device.
// - Data line changes with clock high are START or STOP, never data.
// - High protect input enables hardware protection; low or floating disables it.
// - Low-supply detector blocks internal erase and write sequencing.
// - Control code 1010 selects memory access; eighth bit one reads, zero writes.
// - Read-direction control byte with protect-register code 0110 gets no acknowledge.
// - No control byte is acknowledged while a programming cycle runs.
package eep_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int FIFO_AW = 1;

  localparam logic [3:0] CTRL_CODE_MEM = 4'hA;
  localparam logic [3:0] CTRL_CODE_WPR = 4'h6;
  localparam logic DIR_READ = 1'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [DATA_W-1:0] IDLE_BYTE = 8'hFF;

  // Filter timing on the link clock
  localparam int LINK_PERIOD_NS = 160;
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
  localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);

  typedef struct packed {
    logic load;
    logic [ADDR_W-1:0] addr;
  } eep_cmd_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eep_memwr_t;

endpackage

// [eep_async_buf.sv]
// Two-entry dual-clock buffer with gray-coded pointers
`timescale 1ns/10ps
module eep_async_buf #(
  parameter int W = 8,
  parameter int AW = 1
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [W-1:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [W-1:0] rd_data_o
);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] FULL_MASK = PW'(3) << (PW - 2);

  logic [W-1:0] store [0:(1<<AW)-1];
  logic [PW-1:0] wbin;
  logic [PW-1:0] rbin;
  logic [PW-1:0] wgray;
  logic [PW-1:0] rgray;
  logic [PW-1:0] rgray_s1;
  logic [PW-1:0] rgray_s2;
  logic [PW-1:0] wgray_s1;
  logic [PW-1:0] wgray_s2;
  logic [PW-1:0] next_wbin;
  logic [PW-1:0] next_rbin;
  logic do_wr;
  logic do_rd;

  assign wr_ready_o = (wgray != (rgray_s2 ^ FULL_MASK));
  assign rd_valid_o = (rgray != wgray_s2);
  assign do_wr = wr_valid_i & wr_ready_o;
  assign do_rd = rd_ready_i & rd_valid_o;
  assign next_wbin = wbin + PW'(1);
  assign next_rbin = rbin + PW'(1);
  assign rd_data_o = store[rbin[AW-1:0]];

  always_ff @(posedge wr_clk_i) begin
    if (do_wr) begin
      store[wbin[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (wr_rst_i) begin
      wbin <= '0;
      wgray <= '0;
      rgray_s1 <= '0;
      rgray_s2 <= '0;
    end else begin
      rgray_s1 <= rgray;
      rgray_s2 <= rgray_s1;
      if (do_wr) begin
        wbin <= next_wbin;
        wgray <= next_wbin ^ (next_wbin >> 1);
      end
    end
  end

  always_ff @(posedge rd_clk_i) begin
    if (rd_rst_i) begin
      rbin <= '0;
      rgray <= '0;
      wgray_s1 <= '0;
      wgray_s2 <= '0;
    end else begin
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
      if (do_rd) begin
        rbin <= next_rbin;
        rgray <= next_rbin ^ (next_rbin >> 1);
      end
    end
  end
endmodule

// [eep_read_path.sv]
// Two-wire serial EEPROM read path: link slave, address pointer and array
`timescale 1ns/10ps
module eep_read_path (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_select_bit_0_i,
  input wire logic chip_select_bit_1_i,
  input wire logic chip_select_bit_2_i,
  input wire logic wp_i,
  input wire logic vcc_low_i,
  input wire logic prog_busy_i,
  input wire eep_pkg::eep_memwr_t mem_wr_i,
  output logic hw_protect_o,
  output logic write_block_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_WADDR,
    ST_WDATA,
    ST_ACK,
    ST_TX,
    ST_MACK
  } eep_link_state_t;

  // Core clock domain
  logic [eep_pkg::DATA_W-1:0] mem [0:eep_pkg::MEM_DEPTH-1];
  logic [eep_pkg::ADDR_W-1:0] ptr;
  logic [eep_pkg::ADDR_W-1:0] next_ptr;
  logic wp_s1, wp_s2, vlow_s1, vlow_s2;
  logic req_s1, req_s2, req_s3;
  logic ack_tgl;
  logic fetch_pend;
  logic buf_wr_ready;
  logic req_edge;
  logic fetch_done;
  logic mem_wr_ok;

  // Link clock domain
  logic lrst_s1;
  logic lrst;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] filt;
  logic [1:0] filt_q;
  logic [1:0] filt_cnt [0:1];
  logic [2:0] cs_s1, cs_s2;
  logic busy_s1, busy_s2, ack_s1, ack_s2;
  logic req_tgl;
  logic pend;
  eep_pkg::eep_cmd_t pend_cmd;
  eep_pkg::eep_cmd_t cmd_hold;
  eep_link_state_t state;
  eep_link_state_t next_state;
  eep_link_state_t ack_next;
  eep_link_state_t next_ack_next;
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic oe;
  logic next_oe;
  logic issue_fetch, issue_load, tx_pop, drain_pop;
  logic buf_rd_valid;
  logic [eep_pkg::DATA_W-1:0] buf_rd_data;

  // Named decode wires on the link side
  logic scl_f, sda_f, scl_rise, scl_fall;
  logic start_cond, stop_cond, byte_full;
  logic code_mem, code_wpr_read, cs_match;
  logic ctrl_ack, ctrl_read, cmd_busy;

  // Core domain logic
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wp_s1 <= 1'h0;
      wp_s2 <= 1'h0;
      vlow_s1 <= 1'h1;
      vlow_s2 <= 1'h1;
      hw_protect_o <= 1'h0;
      write_block_o <= 1'h1;
    end else begin
      wp_s1 <= wp_i;
      wp_s2 <= wp_s1;
      vlow_s1 <= vcc_low_i;
      vlow_s2 <= vlow_s1;
      hw_protect_o <= wp_s2;
      write_block_o <= vlow_s2;
    end
  end

  // writes gated by supply and protect
  assign mem_wr_ok = mem_wr_i.we & ~write_block_o & ~hw_protect_o;

  always_ff @(posedge clk_i) begin
    if (mem_wr_ok) begin
      mem[mem_wr_i.addr] <= mem_wr_i.data;
    end
  end

  assign req_edge = req_s2 ^ req_s3;
  assign fetch_done = fetch_pend & buf_wr_ready;

  assign next_ptr = ptr + eep_pkg::ADDR_W'(1);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_s1 <= 1'h0;
      req_s2 <= 1'h0;
      req_s3 <= 1'h0;
      ack_tgl <= 1'h0;
      fetch_pend <= 1'h0;
      ptr <= '0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_edge && cmd_hold.load) begin
        ptr <= cmd_hold.addr;
        ack_tgl <= ~ack_tgl;
      end else if (req_edge) begin
        fetch_pend <= 1'h1;
      end else if (fetch_done) begin
        ptr <= next_ptr;
        fetch_pend <= 1'h0;
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  // Stall on a full buffer keeps the fetch pending
  eep_async_buf #(
    .W(eep_pkg::DATA_W),
    .AW(eep_pkg::FIFO_AW)
  ) u_buf (
    .wr_clk_i(clk_i),
    .wr_rst_i(sys_rst_i),
    .wr_valid_i(fetch_pend),
    .wr_ready_o(buf_wr_ready),
    .wr_data_i(mem[ptr]),
    .rd_clk_i(link_clk_i),
    .rd_rst_i(lrst),
    .rd_valid_o(buf_rd_valid),
    .rd_ready_i(tx_pop | drain_pop),
    .rd_data_o(buf_rd_data)
  );

  // Link domain logic
  // Reset bridge: a short core reset still reaches the slower link clock
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lrst_s1 <= 1'h1;
      lrst <= 1'h1;
    end else begin
      lrst_s1 <= 1'h0;
      lrst <= lrst_s1;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge link_clk_i) begin
      if (lrst) begin
        pin_s1[i] <= 1'h1;
        pin_s2[i] <= 1'h1;
        filt[i] <= 1'h1;
        filt_q[i] <= 1'h1;
        filt_cnt[i] <= 2'h0;
      end else begin
        pin_s1[i] <= (i == 0) ? scl_i : sda_i;
        pin_s2[i] <= pin_s1[i];
        filt_q[i] <= filt[i];
        if (pin_s2[i] == filt[i]) begin
          filt_cnt[i] <= 2'h0;
        end else if (filt_cnt[i] == eep_pkg::FILT_LAST) begin
          filt[i] <= pin_s2[i];
          filt_cnt[i] <= 2'h0;
        end else begin
          filt_cnt[i] <= filt_cnt[i] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      cs_s1 <= 3'h0;
      cs_s2 <= 3'h0;
      busy_s1 <= 1'h0;
      busy_s2 <= 1'h0;
      ack_s1 <= 1'h0;
      ack_s2 <= 1'h0;
    end else begin
      cs_s1 <= {chip_select_bit_2_i, chip_select_bit_1_i, chip_select_bit_0_i};
      cs_s2 <= cs_s1;
      busy_s1 <= prog_busy_i;
      busy_s2 <= busy_s1;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign scl_rise = scl_f & ~filt_q[0];
  assign scl_fall = ~scl_f & filt_q[0];
  // data edges with clock high are conditions
  assign start_cond = scl_f & filt_q[0] & filt_q[1] & ~sda_f;
  assign stop_cond = scl_f & filt_q[0] & ~filt_q[1] & sda_f;
  assign byte_full = (bit_cnt == eep_pkg::BITS_PER_BYTE);

  assign code_mem = (sr[7:4] == eep_pkg::CTRL_CODE_MEM);
  assign code_wpr_read = (sr[7:4] == eep_pkg::CTRL_CODE_WPR) & (sr[0] == eep_pkg::DIR_READ);
  // sequential reads never leave this device
  assign cs_match = (sr[3:1] == cs_s2);
  assign ctrl_ack = code_mem & ~code_wpr_read & cs_match & ~busy_s2;
  assign ctrl_read = (sr[0] == eep_pkg::DIR_READ);
  assign cmd_busy = (req_tgl != ack_s2);
  // Stale bytes of an aborted read are thrown away
  assign drain_pop = buf_rd_valid & ((state == ST_IDLE) | (state == ST_CTRL));

  always_comb begin
    next_state = state;
    next_ack_next = ack_next;
    next_sr = sr;
    next_tx = tx;
    next_bit_cnt = bit_cnt;
    next_oe = oe;
    issue_fetch = 1'h0;
    issue_load = 1'h0;
    tx_pop = 1'h0;
    if (stop_cond) begin
      next_state = ST_IDLE;
      next_oe = 1'h0;
    end else if (start_cond) begin
      next_state = ST_CTRL;
      next_bit_cnt = 4'h0;
      next_oe = 1'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_oe = 1'h0;
        end
        ST_CTRL, ST_WADDR, ST_WDATA: begin
          if (scl_rise && !byte_full) begin
            next_sr = {sr[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && byte_full) begin
            next_bit_cnt = 4'h0;
            next_state = ST_ACK;
            next_oe = 1'h1;
            if (state == ST_CTRL) begin
              if (!ctrl_ack) begin
                next_state = ST_IDLE;
                next_oe = 1'h0;
              end else if (ctrl_read) begin
                next_ack_next = ST_TX;
                issue_fetch = 1'h1;
              end else begin
                next_ack_next = ST_WADDR;
              end
            end else if (state == ST_WADDR) begin
              issue_load = 1'h1;
              next_ack_next = ST_WDATA;
            end else begin
              next_ack_next = ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            next_state = ack_next;
            next_oe = 1'h0;
            if (ack_next == ST_TX) begin
              tx_pop = buf_rd_valid;
              next_tx = buf_rd_valid ? buf_rd_data : eep_pkg::IDLE_BYTE;
              next_oe = buf_rd_valid & ~buf_rd_data[7];
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && byte_full) begin
            next_oe = 1'h0;
            next_state = ST_MACK;
          end else if (scl_fall) begin
            next_tx = {tx[6:0], 1'h1};
            next_oe = ~tx[6];
          end
        end
        ST_MACK: begin
          if (scl_rise && !sda_f) begin
            // master acknowledge asks for next byte
            next_state = ST_ACK;
            issue_fetch = 1'h1;
          end else if (scl_rise) begin
            next_state = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      sr <= 8'h00;
      tx <= 8'hFF;
      bit_cnt <= 4'h0;
      oe <= 1'h0;
    end else begin
      state <= next_state;
      ack_next <= next_ack_next;
      sr <= next_sr;
      tx <= next_tx;
      bit_cnt <= next_bit_cnt;
      oe <= next_oe;
    end
  end

  // Command handshake toward the core domain
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      pend <= 1'h0;
      pend_cmd <= '0;
      cmd_hold <= '0;
      req_tgl <= 1'h0;
    end else if (issue_fetch || issue_load) begin
      pend <= 1'h1;
      pend_cmd <= '{load: issue_load, addr: sr};
    end else if (pend && !cmd_busy) begin
      cmd_hold <= pend_cmd;
      req_tgl <= ~req_tgl;
      pend <= 1'h0;
    end
  end

  assign sda_o = 1'h0;
  assign sda_oe_o = oe;
endmodule

// [eep_read_path_props.sv]
// Port checker of the serial EEPROM read path
`timescale 1ns/10ps
module eep_read_path_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic chip_select_bit_0_i,
  input wire logic chip_select_bit_1_i,
  input wire logic chip_select_bit_2_i,
  input wire logic wp_i,
  input wire logic vcc_low_i,
  input wire logic prog_busy_i,
  input wire eep_pkg::eep_memwr_t mem_wr_i,
  input wire logic hw_protect_o,
  input wire logic write_block_o
);
  logic [6:0] cnt;
  logic settled;
  logic busy_txn;
  logic link_off;
  assign settled = cnt[6];
  // Link checks wait until the link side has left reset
  assign link_off = sys_rst_i | ~settled;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) cnt <= 7'h00;
    else if (!settled) cnt <= cnt + 7'h01;
  end
  // Transaction opened while busy
  always_ff @(posedge link_clk_i) begin
    if (sys_rst_i) busy_txn <= 1'b0;
    else if (scl_i && $fell(sda_i)) busy_txn <= prog_busy_i;
    else if (!prog_busy_i) busy_txn <= 1'b0;
  end
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  sequence s_late;
    !scl_i && !$past(scl_i, 3);
  endsequence
  property p_hw_prot;
    @(posedge clk_i) disable iff (sys_rst_i) settled |-> hw_protect_o == $past(wp_i, 3);
  endproperty
  property p_wr_block;
    @(posedge clk_i) disable iff (sys_rst_i) settled |-> write_block_o == $past(vcc_low_i, 3);
  endproperty
  property p_sda_zero;
    @(posedge link_clk_i) disable iff (link_off) sda_o == 1'b0;
  endproperty
  property p_oe_scl_low;
    @(posedge link_clk_i) disable iff (link_off) $changed(sda_oe_o) |-> !scl_i;
  endproperty
  property p_rise_late;
    @(posedge link_clk_i) disable iff (link_off) $rose(sda_oe_o) |-> s_late;
  endproperty
  property p_rise_hold;
    @(posedge link_clk_i) disable iff (link_off) $rose(sda_oe_o) |=> sda_oe_o [*8];
  endproperty
  property p_fall_hold;
    @(posedge link_clk_i) disable iff (link_off) $fell(sda_oe_o) |=> (!sda_oe_o) [*8];
  endproperty
  property p_stop_quiet;
    @(posedge link_clk_i) disable iff (link_off) s_stop |=> (!sda_oe_o) [*8];
  endproperty
  property p_busy;
    @(posedge link_clk_i) disable iff (link_off) busy_txn |-> !sda_oe_o;
  endproperty
  a_hw_prot: assert property (p_hw_prot) else $error("protect flag off pin");
  a_wr_block: assert property (p_wr_block) else $error("write block off detector");
  a_sda_zero: assert property (p_sda_zero) else $error("data drive not low");
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  a_rise_late: assert property (p_rise_late) else $error("drive not after clock fall");
  a_rise_hold: assert property (p_rise_hold) else $error("low drive too short");
  a_fall_hold: assert property (p_fall_hold) else $error("release too short");
  a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
  a_busy: assert property (p_busy) else $error("answered while busy");
endmodule
bind eep_read_path eep_read_path_props eep_read_path_props_inst (
  .clk_i, .sys_rst_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .chip_select_bit_0_i, .chip_select_bit_1_i,
  .chip_select_bit_2_i, .wp_i, .vcc_low_i, .prog_busy_i, .mem_wr_i, .hw_protect_o, .write_block_o
);

// [eep_master_model.sv]
// Behavioural two-wire bus master
`timescale 1ns/10ps
module eep_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_o = 1'b1;
    wt(100);
    scl_o = 1'b1;
    wt(200);
    sda_o = 1'b0;
    wt(200);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    wt(100);
    sda_o = 1'b0;
    wt(100);
    scl_o = 1'b1;
    wt(200);
    sda_o = 1'b1;
    wt(200);
  endtask
  // data moves only with clock low
  task automatic bit_x(input logic b, output logic r);
    wt(100);
    sda_o = b;
    wt(100);
    scl_o = 1'b1;
    wt(200);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
    logic b;
    r = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], b);
      r = {r[6:0], b};
    end
    bit_x(mack, ack);
  endtask
endmodule

// [eep_read_path_tb.sv]
// Self-checking bench of the serial EEPROM read path
`timescale 1ns/10ps
module eep_read_path_tb;
  logic clk_i;
  logic link_clk_i;
  logic sys_rst_i;
  logic scl;
  logic m_sda;
  logic sda_w;
  logic sda_val;
  logic sda_oe;
  logic [2:0] cs;
  logic wp;
  logic vcc_low;
  logic busy;
  eep_pkg::eep_memwr_t mem_wr;
  logic hw_protect;
  logic write_block;
  logic [7:0] rdc;
  logic [7:0] wrc;
  logic [7:0] q;
  logic a;
  int n_mismatch;
  int cmp_count;
  // Pull-up wire, low when any party drives
  assign sda_w = m_sda & ~sda_oe;
  assign rdc = {eep_pkg::CTRL_CODE_MEM, cs, eep_pkg::DIR_READ};
  assign wrc = {eep_pkg::CTRL_CODE_MEM, cs, 1'b0};
  eep_read_path eep_read_path_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_val),
    .sda_oe_o(sda_oe), .chip_select_bit_0_i(cs[0]), .chip_select_bit_1_i(cs[1]), .chip_select_bit_2_i(cs[2]),
    .wp_i(wp), .vcc_low_i(vcc_low), .prog_busy_i(busy), .mem_wr_i(mem_wr), .hw_protect_o(hw_protect),
    .write_block_o(write_block)
  );
  eep_master_model mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end
  function automatic logic [7:0] pat(input logic [7:0] x);
    return x ^ 8'h5A;
  endfunction
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fill1(input logic [7:0] ad, input logic [7:0] d);
    mem_wr = {1'b1, ad, d};
    mst.wt(1);
    mem_wr.we = 1'b0;
    mst.wt(1);
  endtask
  task automatic send(input logic [7:0] d, input logic nack);
    mst.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, {7'h0, nack});
  endtask
  task automatic get(input logic mack, input logic [7:0] exp);
    mst.xfer(8'hFF, mack, q, a);
    chk(q, exp);
  endtask
  task automatic cur(input logic [7:0] exp);
    mst.start();
    send(rdc, 1'b0);
    get(1'b1, exp);
    mst.stop();
  endtask
  task automatic rnd(input logic [7:0] ad);
    mst.start();
    send(wrc, 1'b0);
    send(ad, 1'b0);
    mst.start();
    send(rdc, 1'b0);
  endtask
  task automatic t_fill();
    for (int i = 0; i < 256; i++) fill1(8'(i), pat(8'(i)));
    chk({7'h0, write_block}, 8'h00);
    chk({7'h0, hw_protect}, 8'h00);
  endtask
  task automatic t_protect();
    wp = 1'b1;
    mst.wt(4);
    chk({7'h0, hw_protect}, 8'h01);
    fill1(8'h10, 8'h00);
    wp = 1'b0;
    vcc_low = 1'b1;
    mst.wt(4);
    chk({7'h0, write_block}, 8'h01);
    fill1(8'h11, 8'h00);
    vcc_low = 1'b0;
    mst.wt(4);
  endtask
  task automatic t_random();
    rnd(8'h10);
    get(1'b1, pat(8'h10));
    mst.stop();
    cur(pat(8'h11));
  endtask
  task automatic t_seq();
    mst.start();
    send(wrc, 1'b0);
    send(8'hFE, 1'b0);
    send(8'h00, 1'b0);
    mst.start();
    send(rdc, 1'b0);
    get(1'b0, pat(8'hFE));
    get(1'b0, pat(8'hFF));
    get(1'b1, pat(8'h00));
    mst.stop();
    cur(pat(8'h01));
  endtask
  task automatic t_refuse();
    for (int i = 0; i < 3; i++) begin
      mst.start();
      send({eep_pkg::CTRL_CODE_MEM, cs ^ 3'(1 << i), eep_pkg::DIR_READ}, 1'b1);
      mst.stop();
    end
    mst.start();
    send({eep_pkg::CTRL_CODE_WPR, cs, eep_pkg::DIR_READ}, 1'b1);
    mst.stop();
    busy = 1'b1;
    mst.wt(200);
    mst.start();
    send(rdc, 1'b1);
    mst.stop();
    busy = 1'b0;
    cs = 3'h2;
    mst.wt(200);
    cur(pat(8'h02));
  endtask
  initial begin
    repeat (99000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    sys_rst_i = 1'b1;
    wp = 1'b0;
    vcc_low = 1'b0;
    busy = 1'b0;
    cs = 3'h5;
    mem_wr = '0;
    n_mismatch = 0;
    cmp_count = 0;
    mst.wt(12);
    sys_rst_i = 1'b0;
    mst.wt(200);
    t_fill();
    t_protect();
    t_random();
    t_seq();
    t_refuse();
    conclude();
  end
endmodule
